// file: common/vsc_cfg.svh
// Constants for the output voltage scale register pair.
// Assumes inclusion by bare name from design files only.
`ifndef VSC_CFG_SVH
`define VSC_CFG_SVH
`define VSC_CMD_LOOP 8'h29
`define VSC_CMD_MON 8'h2A
`define VSC_EXP_VAL 5'h1D
`define VSC_EXP_HI 15
`define VSC_EXP_LO 11
`define VSC_ZERO_HI 10
`define VSC_ZERO_LO 4
`define VSC_MANT_HI 3
`define VSC_EXT_MANT 4'h8
`define VSC_RST_MANT_G0125 4'h1
`define VSC_RST_MANT_G025 4'h2
`define VSC_RST_MANT_G05 4'h4
`define VSC_RST_MANT_G1 4'h8
`define VSC_MANT_RESET 4'h8
`endif

// file: common/vsc_gain_if.sv
// Carries a mantissa to the quantizer and the gain code back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface vsc_gain_if;
   logic [3:0] mant;
   vsc_pkg::vsc_gain_e gain;
   modport quant (input mant, output gain);
   modport user (output mant, input gain);
endinterface

// file: common/vsc_pkg.sv
// Types shared by the scale register bank and its gain quantizer.
// Assumes nothing of its surroundings.
package vsc_pkg;
   typedef enum logic [1:0] {
      VSC_G0125 = 2'b00,
      VSC_G025 = 2'b01,
      VSC_G05 = 2'b10,
      VSC_G1 = 2'b11
   } vsc_gain_e;

   typedef enum logic {
      VSC_INIT = 1'b0,
      VSC_RUN = 1'b1
   } vsc_state_e;

   // Divider gain picked by the highest set mantissa bit
   function automatic vsc_gain_e gainOf(input logic [3:0] mant);
      if (mant[3]) begin
         gainOf = VSC_G1;
      end else if (mant[2]) begin
         gainOf = VSC_G05;
      end else if (mant[1]) begin
         gainOf = VSC_G025;
      end else begin
         gainOf = VSC_G0125;
      end
   endfunction
endpackage

// file: hdl/vsc_gain_quant.sv
// Maps a scale mantissa onto one of the four supported divider gains.
// Assumes the user end holds the mantissa steady for a cycle.
`timescale 1ns/1ns
module vsc_gain_quant (
   vsc_gain_if.quant gq
);
   always_comb begin
      gq.gain = vsc_pkg::gainOf(gq.mant);
   end
endmodule

// file: hdl/vsc_scale_regs.sv
// Loop and monitor output voltage scale registers with word access.
// Assumes an upstream PMBus decoder that turns word transactions into
// one-cycle read and write strobes with the command code, and straps
// that are synchronous to clk and stable after reset release.
//
// How it works
// - bits 15:11 read fixed exponent -3
// - bits 10:4 read as zero
// - only bits 3:0 writable mantissa
// - external divider forces loop mantissa 8
// - loop writes need internal divider, rail disabled
// - override clear loads mantissa from pin
// - any stored mantissa reads back unchanged
// - mantissa ranges quantize to four gains
// - restore loads 1,2,4,8 per gain
// - internal divider: monitor mirrors loop, locked
// - monitor writable only with external divider
// - external divider applies monitor scale instead
// - monitor writes take effect immediately
`timescale 1ns/1ns
`include "vsc_cfg.svh"
module vsc_scale_regs #(
   parameter int MANT_W = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] wrData,
   input wire logic dividerSelectStrap,
   input wire logic railDisabled,
   input wire logic strapOverrideBit,
   input wire logic [3:0] voltageSelectPin,
   input wire logic eepromRestore,
   input wire vsc_pkg::vsc_gain_e restoreLoopGain,
   input wire vsc_pkg::vsc_gain_e restoreMonGain,
   output logic [15:0] rdData,
   output logic rdValid,
   output logic wrAccepted,
   output logic wrRefused,
   output logic cmdUnsupported,
   output logic [3:0] loopMant,
   output logic [3:0] monMant,
   output vsc_pkg::vsc_gain_e appliedGain
);
   generate
      if (MANT_W != 4) begin : g_badWidth
         $error("vsc_scale_regs supports a 4-bit mantissa only");
      end
   endgenerate

   vsc_pkg::vsc_state_e state;
   vsc_gain_if gq ();
   logic extDiv;
   logic isLoop;
   logic isMon;
   logic loopWrOk;
   logic monWrOk;
   logic [3:0] wrMant;

   assign extDiv = dividerSelectStrap;
   assign isLoop = cmdCode == `VSC_CMD_LOOP;
   assign isMon = cmdCode == `VSC_CMD_MON;
   // only the low nibble is taken
   assign wrMant = wrData[`VSC_MANT_HI:0];
   assign loopWrOk = wrStrobe && isLoop && !extDiv && railDisabled && state == vsc_pkg::VSC_RUN;
   assign monWrOk = wrStrobe && isMon && extDiv && state == vsc_pkg::VSC_RUN;

   function automatic logic [3:0] restoreMant(input vsc_pkg::vsc_gain_e g);
      unique case (g)
         vsc_pkg::VSC_G0125: restoreMant = `VSC_RST_MANT_G0125;
         vsc_pkg::VSC_G025: restoreMant = `VSC_RST_MANT_G025;
         vsc_pkg::VSC_G05: restoreMant = `VSC_RST_MANT_G05;
         vsc_pkg::VSC_G1: restoreMant = `VSC_RST_MANT_G1;
      endcase
   endfunction

   // Straps are caught one edge after release, never inside the reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= vsc_pkg::VSC_INIT;
      end else begin
         unique case (state)
            vsc_pkg::VSC_INIT: state <= vsc_pkg::VSC_RUN;
            vsc_pkg::VSC_RUN: state <= vsc_pkg::VSC_RUN;
         endcase
      end
   end

   // Restore beats a host write landing in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         loopMant <= `VSC_MANT_RESET;
      end else if (state == vsc_pkg::VSC_INIT) begin
         loopMant <= strapOverrideBit ? restoreMant(restoreLoopGain) : voltageSelectPin;
      end else if (extDiv) begin
         loopMant <= `VSC_EXT_MANT;
      end else if (eepromRestore) begin
         loopMant <= restoreMant(restoreLoopGain);
      end else if (loopWrOk) begin
         loopMant <= wrMant;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         monMant <= `VSC_MANT_RESET;
      end else if (!extDiv && state == vsc_pkg::VSC_RUN) begin
         monMant <= loopMant;
      end else if (state == vsc_pkg::VSC_INIT) begin
         monMant <= strapOverrideBit ? restoreMant(restoreMonGain) : voltageSelectPin;
      end else if (eepromRestore) begin
         monMant <= restoreMant(restoreMonGain);
      end else if (monWrOk) begin
         // no wait for disable or reset
         monMant <= wrMant;
      end
   end

   // monitor scale steers the divider when external
   assign gq.mant = extDiv ? monMant : loopMant;
   vsc_gain_quant u_quant (
      .gq(gq.quant)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         appliedGain <= vsc_pkg::VSC_G1;
      end else begin
         appliedGain <= gq.gain;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData <= 16'h0000;
         rdValid <= 1'b0;
      end else begin
         rdValid <= rdStrobe;
         if (rdStrobe && (isLoop || isMon)) begin
            rdData <= {`VSC_EXP_VAL, 7'h00, isLoop ? loopMant : monMant};
         end else begin
            rdData <= 16'h0000;
         end
      end
   end

   // refused writes only raise a flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrAccepted <= 1'b0;
         wrRefused <= 1'b0;
         cmdUnsupported <= 1'b0;
      end else begin
         wrAccepted <= loopWrOk || monWrOk;
         wrRefused <= wrStrobe && (isLoop || isMon) && !(loopWrOk || monWrOk);
         cmdUnsupported <= (wrStrobe || rdStrobe) && !(isLoop || isMon);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   expBits_a: assert property (rdValid |-> rdData[15:11] == `VSC_EXP_VAL)
      else $error("exponent field wrong");
   zeroBits_a: assert property (rdValid |-> rdData[10:4] == 7'h00)
      else $error("reserved bits not zero");
   readAns_a: assert property (rdStrobe |=> rdValid)
      else $error("read not answered next cycle");
   extForce_a: assert property (extDiv && state == vsc_pkg::VSC_RUN
         |=> loopMant == `VSC_EXT_MANT)
      else $error("loop mantissa not forced");
   loopKeep_a: assert property (wrStrobe && isLoop && extDiv
         && state == vsc_pkg::VSC_RUN |=> wrRefused && loopMant == `VSC_EXT_MANT)
      else $error("loop write taken with external divider");
   // Restore and the init load may legally move the loop value under a refused write
   loopLock_a: assert property (wrStrobe && isLoop && !railDisabled && !eepromRestore
         && state == vsc_pkg::VSC_RUN |=> wrRefused && $stable(loopMant))
      else $error("loop write taken while enabled");
   loopStore_a: assert property (loopWrOk && !eepromRestore
         |=> loopMant == $past(wrMant))
      else $error("loop write not stored");
   pinLoad_a: assert property (state == vsc_pkg::VSC_INIT && !strapOverrideBit
         |=> loopMant == $past(voltageSelectPin))
      else $error("pin value not loaded");
   restore_a: assert property (eepromRestore && !extDiv && state == vsc_pkg::VSC_RUN
         |=> loopMant == restoreMant($past(restoreLoopGain)))
      else $error("restore mantissa wrong");
   monMirror_a: assert property (!extDiv && state == vsc_pkg::VSC_RUN
         |=> monMant == $past(loopMant))
      else $error("monitor does not mirror loop");
   monRefuse_a: assert property (wrStrobe && isMon && !extDiv |=> wrRefused)
      else $error("monitor write taken with internal divider");
   monHold_a: assert property (extDiv && !monWrOk && !eepromRestore
         && state == vsc_pkg::VSC_RUN |=> $stable(monMant))
      else $error("monitor changed without write");
   monApply_a: assert property (monWrOk && !eepromRestore && $stable(dividerSelectStrap)
         ##1 extDiv |=> appliedGain == vsc_pkg::gainOf($past(wrMant, 2)))
      else $error("monitor write not applied at once");
   // Range bounds written out so a wrong quantizer table cannot hide behind itself
   gainMap_a: assert property (##1 1'b1
         |-> appliedGain == ($past(gq.mant) >= 4'h8 ? vsc_pkg::VSC_G1
         : $past(gq.mant) >= 4'h4 ? vsc_pkg::VSC_G05
         : $past(gq.mant) >= 4'h2 ? vsc_pkg::VSC_G025 : vsc_pkg::VSC_G0125))
      else $error("applied gain mismatch");

   loopWr_c: cover property (loopWrOk);
   monWr_c: cover property (monWrOk);
   restore_c: cover property (eepromRestore && state == vsc_pkg::VSC_RUN);
   refused_c: cover property (wrRefused);
   monApply_c: cover property (monWrOk ##1 extDiv);
endmodule

// file: sim/testbench.sv
// Self-checking bench for the scale register pair.
// Assumes the host model answers with flags {valid, accepted, refused, unsupported}.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic strap = 1'b0;
   logic railOff = 1'b1;
   logic ovr = 1'b0;
   logic restore = 1'b0;
   logic [3:0] pin = 4'h5;
   vsc_pkg::vsc_gain_e rLoop = vsc_pkg::VSC_G025;
   vsc_pkg::vsc_gain_e rMon = vsc_pkg::VSC_G05;
   logic wrS, rdS, rdValid, wrAcc, wrRef, cmdUns;
   logic [7:0] cmd;
   logic [15:0] wd, rdData;
   logic [3:0] loopMant, monMant;
   vsc_pkg::vsc_gain_e gain;
   int nFail = 0;
   int cmpCount = 0;
   int cycles = 0;
   always #25 clk = ~clk;
   vsc_host_model u_host (.clk(clk), .wrStrobe(wrS), .rdStrobe(rdS), .cmdCode(cmd),
      .wrData(wd), .rdData(rdData), .flags({rdValid, wrAcc, wrRef, cmdUns}));
   vsc_scale_regs u_dut (.clk(clk), .rstn(rstn), .wrStrobe(wrS), .rdStrobe(rdS),
      .cmdCode(cmd), .wrData(wd), .dividerSelectStrap(strap), .railDisabled(railOff),
      .strapOverrideBit(ovr), .voltageSelectPin(pin), .eepromRestore(restore),
      .restoreLoopGain(rLoop), .restoreMonGain(rMon), .rdData(rdData),
      .rdValid(rdValid), .wrAccepted(wrAcc), .wrRefused(wrRef), .cmdUnsupported(cmdUns),
      .loopMant(loopMant), .monMant(monMant), .appliedGain(gain));
   task automatic stopTest();
      $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         nFail++;
         stopTest();
      end
   end
   function automatic logic [1:0] eg(input logic [3:0] m);
      return m >= 4'h8 ? 2'h3 : m >= 4'h4 ? 2'h2 : m >= 4'h2 ? 2'h1 : 2'h0;
   endfunction
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [3:0] ef);
      logic [15:0] q;
      logic [3:0] f;
      u_host.xfer(1'b0, c, d, q, f);
      `CHK("write flags", ef, f)
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] ed);
      logic [15:0] q;
      logic [3:0] f;
      u_host.xfer(1'b1, c, 16'h0000, q, f);
      `CHK("read data", ed, q)
      `CHK("read valid", 1'h1, f[3])
      `CHK("unsupported", (c != 8'h29 && c != 8'h2A), f[0])
   endtask
   task automatic edge1();
      @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (2) edge1();
      `CHK("pin mantissa", 4'h5, loopMant)
      `CHK("mirror", 4'h5, monMant)
      rd(8'h29, 16'hE805);
      for (int m = 0; m < 16; m++) begin
         wr(8'h29, {12'hFFF, m[3:0]}, 4'h4);
         rd(8'h29, {12'hE80, m[3:0]});
         `CHK("gain", eg(m[3:0]), gain)
      end
      rd(8'h2A, 16'hE80F);
      wr(8'h2A, 16'h0003, 4'h2);
      railOff = 1'b0;
      wr(8'h29, 16'h0002, 4'h2);
      rd(8'h29, 16'hE80F);
      for (int g = 3; g >= 0; g--) begin
         rLoop = vsc_pkg::vsc_gain_e'(g);
         restore = 1'b1;
         edge1();
         restore = 1'b0;
         edge1();
         `CHK("restore", 4'h1 << g, loopMant)
      end
      strap = 1'b1;
      railOff = 1'b1;
      edge1();
      `CHK("forced loop", 4'h8, loopMant)
      wr(8'h29, 16'h0003, 4'h2);
      // gain 0.25 suits a 3 V sense
      wr(8'h2A, 16'h0003, 4'h4);
      `CHK("monitor now", 4'h3, monMant)
      edge1();
      `CHK("monitor gain", vsc_pkg::VSC_G025, gain)
      rd(8'h2A, 16'hE803);
      rMon = vsc_pkg::VSC_G1;
      restore = 1'b1;
      edge1();
      restore = 1'b0;
      `CHK("monitor restore", 4'h8, monMant)
      `CHK("loop still forced", 4'h8, loopMant)
      rd(8'h2B, 16'h0000);
      ovr = 1'b1;
      strap = 1'b0;
      rLoop = vsc_pkg::VSC_G05;
      rstn = 1'b0;
      edge1();
      rstn = 1'b1;
      repeat (2) edge1();
      `CHK("nvm loop", 4'h4, loopMant)
      `CHK("nvm mirror", 4'h4, monMant)
      stopTest();
   end
endmodule

// file: sim/vsc_host_model.sv
// Host stand-in that issues word transfers as one-cycle strobes.
// Assumes the answer arrives one clock after the strobe is driven.
`timescale 1ns/1ns
module vsc_host_model (
   input wire logic clk,
   output logic wrStrobe,
   output logic rdStrobe,
   output logic [7:0] cmdCode,
   output logic [15:0] wrData,
   input wire logic [15:0] rdData,
   input wire logic [3:0] flags
);
   initial begin
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      cmdCode = 8'h00;
      wrData = 16'h0000;
   end
   // Released command and data lines go to the inverse so a stale value cannot pass; strobes drop low
   task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d,
         output logic [15:0] q, output logic [3:0] f);
      @(posedge clk);
      #1;
      rdStrobe = rd;
      wrStrobe = !rd;
      cmdCode = c;
      wrData = d;
      @(posedge clk);
      #1;
      rdStrobe = 1'b0;
      wrStrobe = 1'b0;
      cmdCode = ~c;
      wrData = ~d;
      q = rdData;
      f = flags;
   endtask
endmodule
